// *** hw/paired_timer.sv ***
// Contract
// - Lower run bit starts and stops the 16-bit timer, or the 32-bit pair in pair mode.
// - With stop-in-idle set the timer halts during idle; clear, it keeps running.
// - Gate bit enables gated accumulation on internal clock; ignored with external clock.
// - Prescale field divides input clock by 1, 8, 64 or 256.
// - Pair-mode bit joins both timers into one 32-bit timer; clear gives two 16-bit.
// - In pair mode upper control bits have no effect; lower control governs.
// - Clock-source bit selects external pin rising edges or the internal clock.
// - A control write while running resets the prescale counter; software should avoid it.
// - Only the upper timer drives the converter trigger output.
// - Unimplemented control bits always read as zero.
// - In pair mode upper count and period hold the high word, lower the low.
// - Pair-mode period match raises the upper timer's match flag.
// - Pair mode flags a match when 32-bit count equals 32-bit period.
`timescale 1ns/100ps
`default_nettype none
module paired_timer (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    // Device state and pins
    input  wire logic        idle_mode,
    input  wire logic        external_count_pin,
    input  wire logic        upper_external_count_pin,
    // Events
    output var  logic        lower_match_flag,
    output var  logic        upper_match_flag,
    output var  logic        adc_trigger
);

    typedef struct packed {
        logic [15:0] ctl_lo;
        logic [15:0] ctl_hi;
        logic [15:0] cnt_lo;
        logic [15:0] cnt_hi;
        logic [15:0] per_lo;
        logic [15:0] per_hi;
        logic [7:0]  pre_lo;
        logic [7:0]  pre_hi;
        logic        pin_lo_prev;
        logic        pin_hi_prev;
        logic        flag_lo;
        logic        flag_hi;
        logic        adc;
        logic        waitreq;
        logic [31:0] rdata;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    logic        ev_lo;
    logic        ev_hi;
    logic        tick_lo;
    logic        tick_hi;
    logic        pair;
    logic        wr_acc;
    logic [31:0] cnt32;
    logic [31:0] per32;

    // Terminal prescale count selected by a control word
    function automatic logic [7:0] ps_limit(input logic [15:0] ctl);
        unique case (ctl[paired_timer_pkg::PS_HI_BIT:paired_timer_pkg::PS_LO_BIT])
            2'h0: ps_limit = paired_timer_pkg::PS_LIMIT_1;
            2'h1: ps_limit = paired_timer_pkg::PS_LIMIT_8;
            2'h2: ps_limit = paired_timer_pkg::PS_LIMIT_64;
            2'h3: ps_limit = paired_timer_pkg::PS_LIMIT_256;
        endcase
    endfunction : ps_limit

    // One counting event of a timer before the prescaler
    function automatic logic src_event(input logic [15:0] ctl, input logic pin,
                                       input logic prev, input logic idle);
        logic run;
        run = ctl[paired_timer_pkg::RUN_BIT]
            & ~(idle & ctl[paired_timer_pkg::IDLE_BIT]);
        if (ctl[paired_timer_pkg::CS_BIT]) begin
            src_event = run & pin & ~prev;
        end else if (ctl[paired_timer_pkg::GATE_BIT]) begin
            src_event = run & pin;
        end else begin
            src_event = run;
        end
    endfunction : src_event

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // Shared decode visible to the checks below
    assign pair    = state_reg.ctl_lo[paired_timer_pkg::PAIR_BIT];
    assign ev_lo   = src_event(state_reg.ctl_lo, external_count_pin,
                               state_reg.pin_lo_prev, idle_mode);
    // The upper timer's own source is dead while paired
    assign ev_hi   = ~pair & src_event(state_reg.ctl_hi, upper_external_count_pin,
                                       state_reg.pin_hi_prev, idle_mode);
    assign tick_lo = ev_lo &&
        (state_reg.pre_lo == ps_limit(state_reg.ctl_lo));
    assign tick_hi = ev_hi &&
        (state_reg.pre_hi == ps_limit(state_reg.ctl_hi));
    assign wr_acc  = write & ~state_reg.waitreq;
    assign cnt32   = {state_reg.cnt_hi, state_reg.cnt_lo};
    assign per32   = {state_reg.per_hi, state_reg.per_lo};

    // Next-state logic: status flag clear first, then counting, then register writes on top
    always_comb begin
        state_next = state_reg;
        state_next.adc = 1'b0;
        state_next.pin_lo_prev = external_count_pin;
        state_next.pin_hi_prev = upper_external_count_pin;

        // Flag clear comes first so a same-cycle match still sets it
        if (wr_acc && address == paired_timer_pkg::OFS_STATUS && byteenable[0]) begin
            state_next.flag_lo = state_reg.flag_lo & ~writedata[0];
            state_next.flag_hi = state_reg.flag_hi & ~writedata[1];
        end

        // Lower prescaler and counter
        if (ev_lo) begin
            state_next.pre_lo = tick_lo ? 8'h00 : state_reg.pre_lo + 8'h01;
        end
        if (tick_lo && pair) begin
            if (cnt32 == per32) begin
                state_next.cnt_lo  = 16'h0000;
                state_next.cnt_hi  = 16'h0000;
                state_next.flag_hi = 1'b1;
                state_next.adc     = 1'b1;
            end else begin
                {state_next.cnt_hi, state_next.cnt_lo} = cnt32 + 32'h0000_0001;
            end
        end else if (tick_lo) begin
            if (state_reg.cnt_lo == state_reg.per_lo) begin
                state_next.cnt_lo  = 16'h0000;
                state_next.flag_lo = 1'b1;
            end else begin
                state_next.cnt_lo = state_reg.cnt_lo + 16'h0001;
            end
        end

        // Upper prescaler and counter, only as an independent timer
        if (ev_hi) begin
            state_next.pre_hi = tick_hi ? 8'h00 : state_reg.pre_hi + 8'h01;
        end
        if (tick_hi) begin
            if (state_reg.cnt_hi == state_reg.per_hi) begin
                state_next.cnt_hi  = 16'h0000;
                state_next.flag_hi = 1'b1;
                state_next.adc     = 1'b1;
            end else begin
                state_next.cnt_hi = state_reg.cnt_hi + 16'h0001;
            end
        end

        // Register writes, taken at the edge where waitrequest is low
        if (wr_acc) begin
            unique case (address)
                paired_timer_pkg::OFS_LOWER_CTL: begin
                    state_next.ctl_lo = merge16(state_reg.ctl_lo, writedata[15:0],
                        byteenable[1:0]) & paired_timer_pkg::LOWER_CTL_MASK;
                    if (state_reg.ctl_lo[paired_timer_pkg::RUN_BIT]) begin
                        state_next.pre_lo = 8'h00;
                    end
                end
                paired_timer_pkg::OFS_UPPER_CTL: begin
                    state_next.ctl_hi = merge16(state_reg.ctl_hi, writedata[15:0],
                        byteenable[1:0]) & paired_timer_pkg::UPPER_CTL_MASK;
                    if (state_reg.ctl_hi[paired_timer_pkg::RUN_BIT] && !pair) begin
                        state_next.pre_hi = 8'h00;
                    end
                end
                paired_timer_pkg::OFS_LOWER_CNT:
                    state_next.cnt_lo = merge16(state_reg.cnt_lo, writedata[15:0],
                                                byteenable[1:0]);
                paired_timer_pkg::OFS_UPPER_CNT:
                    state_next.cnt_hi = merge16(state_reg.cnt_hi, writedata[15:0],
                                                byteenable[1:0]);
                paired_timer_pkg::OFS_LOWER_PER:
                    state_next.per_lo = merge16(state_reg.per_lo, writedata[15:0],
                                                byteenable[1:0]);
                paired_timer_pkg::OFS_UPPER_PER:
                    state_next.per_hi = merge16(state_reg.per_hi, writedata[15:0],
                                                byteenable[1:0]);
                default: ;
            endcase
        end

        // One wait state: read data are captured as waitrequest drops
        state_next.waitreq = ~((read | write) & state_reg.waitreq);
        if (read && state_reg.waitreq) begin
            unique case (address)
                paired_timer_pkg::OFS_LOWER_CTL: state_next.rdata = {16'h0000, state_reg.ctl_lo};
                paired_timer_pkg::OFS_UPPER_CTL: state_next.rdata = {16'h0000, state_reg.ctl_hi};
                paired_timer_pkg::OFS_LOWER_CNT: state_next.rdata = {16'h0000, state_reg.cnt_lo};
                paired_timer_pkg::OFS_UPPER_CNT: state_next.rdata = {16'h0000, state_reg.cnt_hi};
                paired_timer_pkg::OFS_LOWER_PER: state_next.rdata = {16'h0000, state_reg.per_lo};
                paired_timer_pkg::OFS_UPPER_PER: state_next.rdata = {16'h0000, state_reg.per_hi};
                paired_timer_pkg::OFS_STATUS:
                    state_next.rdata = {30'h0000_0000, state_reg.flag_hi, state_reg.flag_lo};
                default: state_next.rdata = 32'h0000_0000;  // Unmapped reads as zero
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= '{ctl_lo: paired_timer_pkg::CTL_RESET,
                           ctl_hi: paired_timer_pkg::CTL_RESET,
                           cnt_lo: paired_timer_pkg::CNT_RESET,
                           cnt_hi: paired_timer_pkg::CNT_RESET,
                           per_lo: paired_timer_pkg::PER_RESET,
                           per_hi: paired_timer_pkg::PER_RESET,
                           pre_lo: 8'h00, pre_hi: 8'h00,
                           pin_lo_prev: 1'b0, pin_hi_prev: 1'b0,
                           flag_lo: 1'b0, flag_hi: 1'b0, adc: 1'b0,
                           waitreq: 1'b1, rdata: 32'h0000_0000};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register
    assign readdata         = state_reg.rdata;
    assign waitrequest      = state_reg.waitreq;
    assign lower_match_flag = state_reg.flag_lo;
    assign upper_match_flag = state_reg.flag_hi;
    assign adc_trigger      = state_reg.adc;

    // Checks
    a_run_stops: assert property (
        @(posedge sys_clk) disable iff (srst)
        (!state_reg.ctl_lo[paired_timer_pkg::RUN_BIT] && !wr_acc)
            |=> $stable(state_reg.cnt_lo) && $stable(state_reg.pre_lo))
        else $error("lower timer moved while stopped");

    a_idle_halts: assert property (
        @(posedge sys_clk) disable iff (srst)
        (idle_mode && state_reg.ctl_lo[paired_timer_pkg::IDLE_BIT] && !wr_acc)
            |=> $stable(state_reg.pre_lo) && $stable(state_reg.cnt_lo))
        else $error("lower timer moved in idle with stop-in-idle set");

    a_gate_blocks: assert property (
        @(posedge sys_clk) disable iff (srst)
        (!state_reg.ctl_lo[paired_timer_pkg::CS_BIT]
            && state_reg.ctl_lo[paired_timer_pkg::GATE_BIT]
            && !external_count_pin && !wr_acc)
            |=> $stable(state_reg.pre_lo) && $stable(state_reg.cnt_lo))
        else $error("gated timer counted with gate low");

    a_prescale_step: assert property (
        @(posedge sys_clk) disable iff (srst)
        (ev_lo && !tick_lo && !wr_acc) |=> state_reg.pre_lo == $past(state_reg.pre_lo) + 8'h01)
        else $error("prescaler did not advance");

    a_pair_wrap: assert property (
        @(posedge sys_clk) disable iff (srst)
        (pair && tick_lo && cnt32 == per32 && !wr_acc)
            |=> cnt32 == 32'h0000_0000 && upper_match_flag && adc_trigger)
        else $error("32-bit match did not wrap and flag upper");

    a_upper_ignored: assert property (
        @(posedge sys_clk) disable iff (srst)
        (pair && !tick_lo && !wr_acc) |=> $stable(state_reg.cnt_hi))
        else $error("upper count moved on its own while paired");

    a_ext_edge: assert property (
        @(posedge sys_clk) disable iff (srst)
        (state_reg.ctl_lo[paired_timer_pkg::CS_BIT]
            && state_reg.ctl_lo[paired_timer_pkg::RUN_BIT]
            && !(idle_mode && state_reg.ctl_lo[paired_timer_pkg::IDLE_BIT])
            && external_count_pin && !state_reg.pin_lo_prev
            && ps_limit(state_reg.ctl_lo) == 8'h00 && !pair && !wr_acc
            && state_reg.cnt_lo != state_reg.per_lo)
            |=> state_reg.cnt_lo == $past(state_reg.cnt_lo) + 16'h0001)
        else $error("external rising edge not counted");

    a_ctl_write_pre: assert property (
        @(posedge sys_clk) disable iff (srst)
        (wr_acc && address == paired_timer_pkg::OFS_LOWER_CTL
            && state_reg.ctl_lo[paired_timer_pkg::RUN_BIT]) |=> state_reg.pre_lo == 8'h00)
        else $error("control write while running kept the prescaler");

    a_trigger_upper: assert property (
        @(posedge sys_clk) disable iff (srst)
        adc_trigger |-> upper_match_flag && $past(tick_hi || (pair && tick_lo)))
        else $error("trigger without an upper timer match");

    a_reserved_zero: assert property (
        @(posedge sys_clk) disable iff (srst)
        (read && !waitrequest && address == paired_timer_pkg::OFS_LOWER_CTL)
            |-> (readdata & ~{16'h0000, paired_timer_pkg::LOWER_CTL_MASK}) == 32'h0000_0000)
        else $error("unimplemented control bits read non-zero");

    a_single_wrap: assert property (
        @(posedge sys_clk) disable iff (srst)
        (!pair && tick_lo && state_reg.cnt_lo == state_reg.per_lo && !wr_acc)
            |=> state_reg.cnt_lo == 16'h0000 && lower_match_flag)
        else $error("16-bit match did not wrap to zero");

endmodule : paired_timer
`default_nettype wire

// *** hw/paired_timer_pkg.sv ***
package paired_timer_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [4:0] OFS_LOWER_CTL = 5'h00;
    localparam logic [4:0] OFS_UPPER_CTL = 5'h04;
    localparam logic [4:0] OFS_LOWER_CNT = 5'h08;
    localparam logic [4:0] OFS_UPPER_CNT = 5'h0C;
    localparam logic [4:0] OFS_LOWER_PER = 5'h10;
    localparam logic [4:0] OFS_UPPER_PER = 5'h14;
    localparam logic [4:0] OFS_STATUS    = 5'h18;

    // Control field positions
    localparam int RUN_BIT   = 15;
    localparam int IDLE_BIT  = 13;
    localparam int GATE_BIT  = 6;
    localparam int PS_HI_BIT = 5;
    localparam int PS_LO_BIT = 4;
    localparam int PAIR_BIT  = 3;
    localparam int CS_BIT    = 1;

    // Implemented control bits; all others read as zero
    localparam logic [15:0] LOWER_CTL_MASK = 16'hA07A;
    localparam logic [15:0] UPPER_CTL_MASK = 16'hA072;

    // Reset values
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] PER_RESET = 16'hFFFF;

    // Prescale terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PS_LIMIT_1   = 8'h00;
    localparam logic [7:0] PS_LIMIT_8   = 8'h07;
    localparam logic [7:0] PS_LIMIT_64  = 8'h3F;
    localparam logic [7:0] PS_LIMIT_256 = 8'hFF;
endpackage : paired_timer_pkg

// *** tb/count_pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module count_pin_model (
    // Clock
    input  wire logic sys_clk,
    // Count and gate pins
    output wire logic external_count_pin,
    output wire logic upper_external_count_pin
);
    // Both pins follow one level, low at rest as a pull-down would leave them
    logic lvl = 1'b0;
    assign external_count_pin       = lvl;
    assign upper_external_count_pin = lvl;

    // Edges four cycles apart, so each rising edge is one clean event
    task automatic send_edges(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            lvl <= 1'b1;
            repeat (2) @(posedge sys_clk);
            lvl <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : send_edges

    // Gate level held high for k cycles, then back to rest
    task automatic hold_high(input int k);
        @(posedge sys_clk);
        lvl <= 1'b1;
        repeat (k) @(posedge sys_clk);
        lvl <= 1'b0;
    endtask : hold_high
endmodule : count_pin_model
`default_nettype wire

// *** tb/paired_timer_16_32_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module paired_timer_16_32_control_tb;
    // Short names for the register offsets
    localparam logic [4:0] LC = paired_timer_pkg::OFS_LOWER_CTL;
    localparam logic [4:0] UC = paired_timer_pkg::OFS_UPPER_CTL;
    localparam logic [4:0] LN = paired_timer_pkg::OFS_LOWER_CNT;
    localparam logic [4:0] UN = paired_timer_pkg::OFS_UPPER_CNT;
    localparam logic [4:0] LP = paired_timer_pkg::OFS_LOWER_PER;
    localparam logic [4:0] UP = paired_timer_pkg::OFS_UPPER_PER;
    localparam logic [4:0] ST = paired_timer_pkg::OFS_STATUS;
    localparam int LIMIT = 20000; // Tests need about 3000 cycles
    typedef struct {logic [4:0] a; logic [15:0] w; logic [15:0] r;} row_t;
    // Each row writes w at a and expects r back; 1C is unmapped
    row_t rows [6] = '{'{LC, 16'h7FFF, 16'h207A}, '{UC, 16'h7FFF, 16'h2072},
                       '{UP, 16'h1234, 16'h1234}, '{5'h1C, 16'hABCD, 16'h0000},
                       '{LC, 16'h0000, 16'h0000}, '{UC, 16'h0000, 16'h0000}};
    int divs [4] = '{1, 8, 64, 256};
    logic        sys_clk, srst, read, write, waitrequest, idle_mode;
    logic        lower_match_flag, upper_match_flag, adc_trigger;
    logic        external_count_pin, upper_external_count_pin;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata;
    logic [15:0] v;
    int          miscompares = 0, n_compared = 0, cycles = 0, trig_n = 0;

    paired_timer i_dut (.sys_clk, .srst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .idle_mode, .external_count_pin, .upper_external_count_pin,
        .lower_match_flag, .upper_match_flag, .adc_trigger);
    count_pin_model pins (.sys_clk, .external_count_pin, .upper_external_count_pin);

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Trigger pulses last one cycle, so they are counted here; also the hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (adc_trigger === 1'b1) trig_n++;
        if (cycles == LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bus cycles hold the request until waitrequest is sampled low
    task automatic bus_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        address   <= a;
        writedata <= {16'h0000, d};
        write     <= 1'b1;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_write

    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk);
        address <= a;
        read    <= 1'b1;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        v = readdata[15:0];
        read <= 1'b0;
    endtask : rd

    task automatic wait_cycles(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : wait_cycles

    // Bounded wait for a match flag
    task automatic wait_flag(input bit upper);
        for (int i = 0; i < 60; i++) begin
            @(posedge sys_clk);
            if ((upper ? upper_match_flag : lower_match_flag) === 1'b1) break;
        end
    endtask : wait_flag

    task automatic done(input string s);
        $display("test %s done, mismatches %0d", s, miscompares);
    endtask : done

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        srst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        idle_mode = 1'b0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            bus_write(rows[i].a, rows[i].w);
            rd(rows[i].a);
            check(v, rows[i].r);
        end
        // A single byte lane leaves the other byte of the period alone
        byteenable <= 4'h1;
        bus_write(LP, 16'h1234);
        byteenable <= 4'hF;
        rd(LP);
        check(v, 16'hFF34);
        done("table");
        // The 1:8, 1:64 and 1:256 divisions each run four and a half counts, so slack of a few cycles is harmless
        for (int k = 1; k < 4; k++) begin
            bus_write(LN, 16'h0000);
            bus_write(LC, 16'h8000 | 16'(k << 4));
            wait_cycles(divs[k] * 4 + divs[k] / 2);
            bus_write(LC, 16'h0000);
            rd(LN);
            check(v, 16'h0004);
        end
        wait_cycles(20);
        rd(LN);
        check(v, 16'h0004);
        done("prescale");
        // External edges at 1:1 with the gate bit set, which must be ignored
        bus_write(LN, 16'h0000);
        bus_write(LC, 16'h8042);
        pins.send_edges(10);
        wait_cycles(4);
        bus_write(LC, 16'h0000);
        rd(LN);
        check(v, 16'h000A);
        rd(UN);
        check(v, 16'h0000);
        // Upper timer alone on its own pin, gate bit again ignored
        bus_write(UC, 16'h8042);
        pins.send_edges(5);
        bus_write(UC, 16'h0000);
        rd(UN);
        check(v, 16'h0005);
        bus_write(UN, 16'h0000);
        // Gated internal clock: still while the pin is low, counts while high
        bus_write(LN, 16'h0000);
        bus_write(LC, 16'h8040);
        wait_cycles(50);
        rd(LN);
        check(v, 16'h0000);
        pins.hold_high(40);
        bus_write(LC, 16'h0000);
        rd(LN);
        check(16'(v > 16'd30 && v < 16'd50), 16'h0001);
        done("clock source");
        // Idle mode halts only with stop-in-idle set
        idle_mode <= 1'b1;
        bus_write(LN, 16'h0000);
        bus_write(LC, 16'hA020);
        wait_cycles(300);
        bus_write(LC, 16'h0000);
        rd(LN);
        check(v, 16'h0000);
        bus_write(LC, 16'h8020);
        wait_cycles(300);
        bus_write(LC, 16'h0000);
        rd(LN);
        check(v, 16'h0004);
        // A rewrite mid-run restarts the prescaler, so neither half reaches 256
        bus_write(LN, 16'h0000);
        bus_write(LC, 16'h8030);
        wait_cycles(200);
        bus_write(LC, 16'h8030);
        wait_cycles(200);
        bus_write(LC, 16'h0000);
        rd(LN);
        check(v, 16'h0000);
        done("idle and rewrite");
        // 16-bit matches: the lower one never triggers the converter
        bus_write(LP, 16'h0005);
        bus_write(UP, 16'h0004);
        bus_write(ST, 16'h0003);
        trig_n = 0;
        bus_write(LC, 16'h8000);
        wait_flag(1'b0);
        wait_cycles(20);
        check(16'(lower_match_flag), 16'h0001);
        check(16'(upper_match_flag), 16'h0000);
        check(16'(trig_n), 16'h0000);
        rd(LN);
        check(16'(v <= 16'h0005), 16'h0001);
        bus_write(UC, 16'h8000);
        wait_flag(1'b1);
        wait_cycles(2);
        check(16'(trig_n > 0), 16'h0001);
        bus_write(LC, 16'h0000);
        bus_write(UC, 16'h0000);
        bus_write(ST, 16'h0003);
        rd(ST);
        check(v, 16'h0000);
        done("16-bit match");
        // Pair mode crossing the word boundary; upper control would halt it if obeyed
        bus_write(LP, 16'h0003);
        bus_write(UP, 16'h0001);
        bus_write(LN, 16'hFFF0);
        bus_write(UN, 16'h0000);
        bus_write(UC, 16'h2072);
        trig_n = 0;
        bus_write(LC, 16'h8008);
        wait_flag(1'b1);
        check(16'(upper_match_flag), 16'h0001);
        check(16'(lower_match_flag), 16'h0000);
        wait_cycles(2);
        check(16'(trig_n), 16'h0001);
        bus_write(LC, 16'h0008);
        rd(UN);
        check(v, 16'h0000);
        done("pair mode");
        // Reset in mid-run brings the registers back to their reset values
        bus_write(LP, 16'h1234);
        bus_write(LC, 16'h8000);
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        rd(LC);
        check(v, 16'h0000);
        rd(LP);
        check(v, 16'hFFFF);
        rd(LN);
        check(v, 16'h0000);
        done("reset");
        complete_run();
    end
endmodule : paired_timer_16_32_control_tb
`default_nettype wire
